/* File: pbc_pkg.sv */
// Constants and carrier types for the expansion bus control block.
// Assumes a single core clock and active-low bus pins sampled via synchronisers.
package pbc_pkg;

  // ---------------------------------------------
  // Bus commands and timing
  // ---------------------------------------------
  localparam logic [3:0] PBC_CMD_IO_READ    = 4'h2;
  localparam logic [3:0] PBC_CMD_IO_WRITE   = 4'h3;
  localparam int         PBC_DEVSEL_TICKS   = 6;
  localparam int         PBC_CNT_W          = 3;
  localparam int         PBC_IRQ_SRC        = 4;
  localparam logic       PBC_TX_DATA_ENABLE_RST      = 1'b1;

  // ---------------------------------------------
  // State machines
  // ---------------------------------------------
  typedef enum logic [3:0] {
    PBC_M_IDLE = 4'b0001,
    PBC_M_ADDR = 4'b0010,
    PBC_M_WAIT = 4'b0100,
    PBC_M_DATA = 4'b1000
  } pbc_mst_e;

  typedef enum logic [1:0] {
    PBC_T_IDLE  = 2'b01,
    PBC_T_CLAIM = 2'b10
  } pbc_tgt_e;

  // Bus pin levels as seen on the input side
  typedef struct packed {
    logic        frame_n;
    logic        irdy_n;
    logic        trdy_n;
    logic        stop_n;
    logic        devsel_n;
    logic        idsel;
    logic        gnt_n;
    logic        par;
    logic [3:0]  cbe_n;
    logic [31:0] ad;
  } pbc_bus_in_s;

endpackage

/* File: pbc_ctrl.sv */
// Bus control sequencer: arbitration, master and target handshakes,
// parity and system error signalling and the interrupt request pin.
// Assumes the bus pins arrive unsynchronised; the wire level is resolved outside.
module pbc_ctrl
  import pbc_pkg::*;
#(
  parameter int DEVSEL_TICKS = pbc_pkg::PBC_DEVSEL_TICKS,
  parameter int IRQ_SRC      = pbc_pkg::PBC_IRQ_SRC
) (
  input  wire logic                       core_clk_in,
  input  wire logic                       reset_n_in,
  input  wire pbc_pkg::pbc_bus_in_s       bus_in,
  input  wire logic                       clk_div2_in,
  input  wire logic                       mst_need_in,
  input  wire logic [31:0]                mst_addr_in,
  input  wire logic [3:0]                 mst_cmd_in,
  input  wire logic                       cfg_stop_in,
  input  wire logic                       fatal_err_in,
  input  wire logic [IRQ_SRC-1:0]         irq_src_in,
  input  wire logic [IRQ_SRC:0]           irq_mask_in,
  input  wire logic [IRQ_SRC:0]           irq_ack_in,
  input  wire logic                       tx_data_enable_in,
  output logic                            req_n_out,
  output logic                            req_oe_out,
  output logic                            frame_n_out,
  output logic                            frame_oe_out,
  output logic                            irdy_n_out,
  output logic                            irdy_oe_out,
  output logic [31:0]                     ad_out,
  output logic [3:0]                      cbe_n_out,
  output logic                            ad_oe_out,
  output logic                            devsel_n_out,
  output logic                            trdy_n_out,
  output logic                            stop_n_out,
  output logic                            tgt_oe_out,
  output logic                            perr_n_out,
  output logic                            perr_oe_out,
  output logic                            serr_oe_out,
  output logic                            inta_oe_out,
  output logic                            mst_done_out,
  output logic                            mst_abort_out,
  output logic                            cfg_access_out,
  output logic                            cfg_write_out,
  output logic                            tx_data_enable_out
);
  import pbc_pkg::*;
  // ---------------------------------------------
  // Input synchronisers and bus tick
  // ---------------------------------------------
  pbc_bus_in_s sync1_q, bus_q, prev_q;
  logic        tick_q, half_q;
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      sync1_q <= '1;
      bus_q   <= '1;
      prev_q  <= '1;
    end
    else
    begin
      sync1_q <= bus_in;
      bus_q   <= sync1_q;
      if (tick_q)
        prev_q <= bus_q;
    end
  // Half rate alternates the tick so every bus step spans two clocks
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      half_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      half_q <= ~half_q;
      tick_q <= clk_div2_in ? half_q : 1'b1;
    end
  wire addr_phase = tick_q && !bus_q.frame_n && prev_q.frame_n;
  wire data_done  = !bus_q.irdy_n && !bus_q.trdy_n;
  wire bus_idle   = bus_q.frame_n && bus_q.irdy_n;

  // ---------------------------------------------
  // Master sequencer
  // ---------------------------------------------
  pbc_mst_e               mst_q;
  pbc_mst_e               mst_d;
  logic [PBC_CNT_W-1:0]   wait_q;
  wire mst_start = tick_q && mst_need_in && !bus_q.gnt_n && bus_idle;
  wire devsel_in = !bus_q.devsel_n;
  wire timeout   = wait_q == PBC_CNT_W'(DEVSEL_TICKS);
  wire mst_end   = tick_q && (data_done || !bus_q.stop_n);
  wire abort_now = tick_q && (mst_q == PBC_M_WAIT) && !devsel_in && timeout;
  always_comb
  begin
    mst_d = mst_q;
    unique case (mst_q)
      PBC_M_IDLE: if (mst_start) mst_d = PBC_M_ADDR;
      PBC_M_ADDR: if (tick_q) mst_d = PBC_M_WAIT;
      PBC_M_WAIT:
        if (tick_q && devsel_in)
          mst_d = PBC_M_DATA;
        else if (abort_now)
          mst_d = PBC_M_IDLE;
      PBC_M_DATA: if (mst_end) mst_d = PBC_M_IDLE;
      default:    mst_d = PBC_M_IDLE;
    endcase
  end
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      mst_q  <= PBC_M_IDLE;
      wait_q <= '0;
    end
    else
    begin
      mst_q <= mst_d;
      if (mst_q != PBC_M_WAIT)
        wait_q <= '0;
      else if (tick_q && !timeout)
        wait_q <= wait_q + 1'b1;
    end
  // Single data phase: frame goes high as irdy comes on
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      req_n_out     <= 1'b1;
      req_oe_out    <= 1'b0;
      frame_n_out   <= 1'b1;
      frame_oe_out  <= 1'b0;
      irdy_n_out    <= 1'b1;
      irdy_oe_out   <= 1'b0;
      ad_out        <= '0;
      cbe_n_out     <= '1;
      ad_oe_out     <= 1'b0;
      mst_done_out  <= 1'b0;
      mst_abort_out <= 1'b0;
    end
    else
    begin
      req_oe_out    <= 1'b1;
      req_n_out     <= !(mst_need_in && mst_d != PBC_M_DATA);
      frame_n_out   <= mst_d != PBC_M_ADDR;
      frame_oe_out  <= mst_d != PBC_M_IDLE;
      irdy_n_out    <= !(mst_d == PBC_M_WAIT || mst_d == PBC_M_DATA);
      irdy_oe_out   <= mst_d != PBC_M_IDLE;
      ad_out        <= mst_addr_in;
      cbe_n_out     <= mst_cmd_in;
      ad_oe_out     <= mst_d == PBC_M_ADDR;
      mst_done_out  <= (mst_q == PBC_M_DATA) && mst_end;
      mst_abort_out <= abort_now;
    end

  // ---------------------------------------------
  // Target sequencer for config accesses
  // ---------------------------------------------
  pbc_tgt_e tgt_q;
  logic     stop_q;
  wire cmd_io   = (bus_q.cbe_n == PBC_CMD_IO_READ) || (bus_q.cbe_n == PBC_CMD_IO_WRITE);
  wire cfg_hit  = addr_phase && bus_q.idsel && cmd_io && mst_q == PBC_M_IDLE;
  wire tgt_exit = tick_q && (stop_q ? bus_q.frame_n : data_done);
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      tgt_q          <= PBC_T_IDLE;
      stop_q         <= 1'b0;
      cfg_access_out <= 1'b0;
      cfg_write_out  <= 1'b0;
    end
    else
    begin
      cfg_access_out <= cfg_hit;
      if (cfg_hit)
        cfg_write_out <= bus_q.cbe_n == PBC_CMD_IO_WRITE;
      unique case (tgt_q)
        PBC_T_IDLE:
          if (cfg_hit)
          begin
            tgt_q  <= PBC_T_CLAIM;
            stop_q <= cfg_stop_in;
          end
        PBC_T_CLAIM:
          if (tgt_exit)
          begin
            tgt_q  <= PBC_T_IDLE;
            stop_q <= 1'b0;
          end
          else if (cfg_stop_in)
            stop_q <= 1'b1;
        default: tgt_q <= PBC_T_IDLE;
      endcase
    end
  // Driven values mirror the state one clock later
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      devsel_n_out <= 1'b1;
      trdy_n_out   <= 1'b1;
      stop_n_out   <= 1'b1;
      tgt_oe_out   <= 1'b0;
    end
    else
    begin
      devsel_n_out <= tgt_q != PBC_T_CLAIM;
      trdy_n_out   <= !(tgt_q == PBC_T_CLAIM && !stop_q);
      stop_n_out   <= !stop_q;
      tgt_oe_out   <= tgt_q == PBC_T_CLAIM;
    end

  // ---------------------------------------------
  // Parity and system error
  // ---------------------------------------------
  logic par_calc_q, par_arm_q, chk_arm_q;
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      par_calc_q  <= 1'b0;
      par_arm_q   <= 1'b0;
      chk_arm_q   <= 1'b0;
      perr_n_out  <= 1'b1;
      perr_oe_out <= 1'b0;
      serr_oe_out <= 1'b0;
    end
    else
    begin
      if (tick_q)
      begin
        par_calc_q <= ^{bus_q.ad, bus_q.cbe_n};
        par_arm_q  <= !bus_q.frame_n || !bus_q.irdy_n;
        chk_arm_q  <= par_arm_q && (par_calc_q != bus_q.par);
        perr_n_out <= !chk_arm_q;
      end
      perr_oe_out <= tgt_q == PBC_T_CLAIM || mst_q != PBC_M_IDLE || !perr_n_out;
      serr_oe_out <= fatal_err_in;
    end

  // ---------------------------------------------
  // Interrupt status and pin
  // ---------------------------------------------
  logic [IRQ_SRC:0] irq_stat_q;
  wire  [IRQ_SRC:0] irq_set = {mst_abort_out, irq_src_in};
  // Set beats acknowledge in the same cycle so no event is lost
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      irq_stat_q         <= '0;
      inta_oe_out        <= 1'b0;
      tx_data_enable_out <= PBC_TX_DATA_ENABLE_RST;
    end
    else
    begin
      irq_stat_q         <= (irq_stat_q & ~irq_ack_in) | irq_set;
      inta_oe_out        <= |(irq_stat_q & ~irq_mask_in);
      tx_data_enable_out <= tx_data_enable_in;
    end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  abort_bound_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    mst_abort_out |-> $past(wait_q) == PBC_CNT_W'(DEVSEL_TICKS) && $past(mst_q) == PBC_M_WAIT)
    else $error("master abort before the device select limit");
  abort_irq_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    mst_abort_out |=> irq_stat_q[IRQ_SRC]) else $error("master abort did not set its interrupt status");
  cfg_claim_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    cfg_hit |=> ##1 !devsel_n_out && tgt_oe_out) else $error("config access not claimed");
  stop_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (stop_q && tgt_q == PBC_T_CLAIM && !bus_q.frame_n) |=> stop_q) else $error("stop dropped early");
  start_idle_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (mst_q == PBC_M_IDLE && mst_d == PBC_M_ADDR) |-> bus_q.frame_n && !bus_q.gnt_n)
    else $error("master started on a busy bus");
  perr_delay_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (tick_q && chk_arm_q) |=> !perr_n_out) else $error("parity error not flagged");
  irq_pin_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (|(irq_stat_q & ~irq_mask_in)) |=> inta_oe_out) else $error("unmasked status without interrupt pin");
  irq_sticky_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (irq_stat_q[0] && !irq_ack_in[0]) |=> irq_stat_q[0]) else $error("status cleared without acknowledge");
  serr_edge_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    fatal_err_in |=> serr_oe_out) else $error("fatal error not reported");
  req_need_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (mst_need_in && mst_q == PBC_M_IDLE) |=> !req_n_out) else $error("bus request missing");
endmodule // pbc_ctrl

/* File: pbc_far_model.sv */
// Far-side agents: arbiter, a claiming target and the bus pull-ups.
// Assumes the bench drives any other agent's pin levels through ext_in.
module pbc_far_model
  import pbc_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  input  wire logic                 claim_in,
  input  wire logic [2:0]           claim_wait_in,
  input  wire logic                 par_flip_in,
  input  wire pbc_pkg::pbc_bus_in_s ext_in,
  input  wire logic                 req_n_in,
  input  wire logic                 req_oe_in,
  input  wire logic                 frame_n_in,
  input  wire logic                 frame_oe_in,
  input  wire logic                 irdy_n_in,
  input  wire logic                 irdy_oe_in,
  input  wire logic [31:0]          ad_in,
  input  wire logic [3:0]           cbe_n_in,
  input  wire logic                 ad_oe_in,
  input  wire logic                 devsel_n_in,
  input  wire logic                 trdy_n_in,
  input  wire logic                 stop_n_in,
  input  wire logic                 tgt_oe_in,
  output pbc_pkg::pbc_bus_in_s      bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import pbc_pkg::*;
  logic        gnt_n_q, hit_q, claim_q, par_q;
  logic [2:0]  wait_q;
  // Released frame and irdy follow ext_in, trdy and devsel the far target; a released stop floats high on its pull-up
  wire         frame_w = frame_oe_in ? frame_n_in : ext_in.frame_n;
  wire         irdy_w  = irdy_oe_in ? irdy_n_in : ext_in.irdy_n;
  wire [31:0]  ad_w    = ad_oe_in ? ad_in : ext_in.ad;
  wire [3:0]   cbe_w   = ad_oe_in ? cbe_n_in : ext_in.cbe_n;
  assign bus_out = '{frame_n: frame_w, irdy_n: irdy_w, trdy_n: tgt_oe_in ? trdy_n_in : ~claim_q,
                     stop_n: tgt_oe_in ? stop_n_in : 1'b1, devsel_n: tgt_oe_in ? devsel_n_in : ~claim_q,
                     idsel: ext_in.idsel, gnt_n: gnt_n_q, par: par_q ^ par_flip_in, cbe_n: cbe_w, ad: ad_w};
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      {gnt_n_q, hit_q, claim_q, par_q, wait_q} <= 7'h40;
    end
    else
    begin
      gnt_n_q <= ~(req_oe_in & ~req_n_in);
      par_q   <= ^{ad_w, cbe_w};
      if (!hit_q && frame_oe_in && !frame_n_in)
        {hit_q, wait_q} <= {1'b1, claim_wait_in};
      else if (hit_q && !frame_oe_in && !irdy_oe_in)
        {hit_q, claim_q} <= 2'h0;
      else if (hit_q && wait_q != 3'h0)
        wait_q <= wait_q - 3'h1;
      else if (hit_q)
        claim_q <= claim_in;
    end
  end
endmodule // pbc_far_model

/* File: pci_bus_control_signalling_tb_top.sv */
// Bench for the bus control sequencer: master, target, errors, interrupt.
// Assumes pbc_far_model stands for arbiter, target and pull-ups.
module pci_bus_control_signalling_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pbc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, div2 = 1'b0, need = 1'b0, stop_c = 1'b0, fatal = 1'b0, txd = 1'b0;
  logic claim = 1'b1, flip = 1'b0;
  logic [2:0] cwait = 3'h0;
  logic [3:0] src = 4'h0;
  logic [4:0] mask = 5'h00, ack = 5'h00;
  pbc_bus_in_s ext = '{frame_n: 1'b1, irdy_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1, devsel_n: 1'b1,
                       idsel: 1'b0, gnt_n: 1'b1, par: 1'b0, cbe_n: 4'h0, ad: 32'h0};
  pbc_bus_in_s bus;
  logic req_n, req_oe, frm_n, frm_oe, irdy_n, irdy_oe, ad_oe, dev_n, trdy_n, stop_n, tgt_oe;
  logic perr_n, perr_oe, serr_oe, inta_oe, done, abrt, cfg, cfg_wr, txd_out;
  logic [31:0] ad;
  logic [3:0] cbe_n;
  logic done_f, end_f, abrt_f, cfg_f, wr_f, dev_f, stop_f, perr_f, serr_f, req_f, tr_f;
  logic [35:0] adr_seen;
  int bad_count = 0, samples_checked = 0, cyc = 0, t1, t2;
  initial forever #5 clk = ~clk;
  pbc_ctrl i_dut (.core_clk_in(clk), .reset_n_in(rst_n), .bus_in(bus), .clk_div2_in(div2),
    .mst_need_in(need), .mst_addr_in(32'h0000_1230), .mst_cmd_in(PBC_CMD_IO_WRITE), .cfg_stop_in(stop_c),
    .fatal_err_in(fatal), .irq_src_in(src), .irq_mask_in(mask), .irq_ack_in(ack), .tx_data_enable_in(txd),
    .req_n_out(req_n), .req_oe_out(req_oe), .frame_n_out(frm_n), .frame_oe_out(frm_oe), .irdy_n_out(irdy_n),
    .irdy_oe_out(irdy_oe), .ad_out(ad), .cbe_n_out(cbe_n), .ad_oe_out(ad_oe), .devsel_n_out(dev_n),
    .trdy_n_out(trdy_n), .stop_n_out(stop_n), .tgt_oe_out(tgt_oe), .perr_n_out(perr_n), .perr_oe_out(perr_oe),
    .serr_oe_out(serr_oe), .inta_oe_out(inta_oe), .mst_done_out(done), .mst_abort_out(abrt),
    .cfg_access_out(cfg), .cfg_write_out(cfg_wr), .tx_data_enable_out(txd_out));
  pbc_far_model i_far (.clk_in(clk), .reset_n_in(rst_n), .claim_in(claim), .claim_wait_in(cwait),
    .par_flip_in(flip), .ext_in(ext), .req_n_in(req_n), .req_oe_in(req_oe), .frame_n_in(frm_n),
    .frame_oe_in(frm_oe), .irdy_n_in(irdy_n), .irdy_oe_in(irdy_oe), .ad_in(ad), .cbe_n_in(cbe_n),
    .ad_oe_in(ad_oe), .devsel_n_in(dev_n), .trdy_n_in(trdy_n), .stop_n_in(stop_n), .tgt_oe_in(tgt_oe),
    .bus_out(bus));
  // Sticky views so one-cycle pulses are never missed
  always @(posedge clk)
  begin
    cyc++;
    if (done === 1'b1) {done_f, end_f} = 2'h3;
    if (abrt === 1'b1) {abrt_f, end_f} = 2'h3;
    if (cfg === 1'b1) {cfg_f, wr_f} = {1'b1, cfg_wr};
    if (tgt_oe === 1'b1 && dev_n === 1'b0) dev_f = 1'b1;
    if (tgt_oe === 1'b1 && stop_n === 1'b0) stop_f = 1'b1;
    if (tgt_oe === 1'b1 && trdy_n === 1'b0) tr_f = 1'b1;
    if (ad_oe === 1'b1) adr_seen = {cbe_n, ad};
    if (perr_oe === 1'b1 && perr_n === 1'b0) perr_f = 1'b1;
    if (serr_oe === 1'b1) serr_f = 1'b1;
    if (req_oe === 1'b1 && req_n === 1'b0) req_f = 1'b1;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic clear_flags();
    {done_f, end_f, abrt_f, cfg_f, wr_f, dev_f, stop_f, perr_f, serr_f, req_f, tr_f} = 11'h0;
  endtask
  task automatic wait_on(ref logic f, input int lim);
    for (int n = 0; n < lim && f !== 1'b1; n++) @(negedge clk);
  endtask
  task automatic m_xfer(input logic d2, input logic cl, input logic [2:0] w, output int t);
    int t0;
    @(negedge clk);
    {div2, claim, cwait} = {d2, cl, w};
    clear_flags();
    need = 1'b1;
    t0 = cyc;
    wait_on(end_f, 80);
    need = 1'b0;
    t = cyc - t0;
    repeat (6) @(negedge clk);
  endtask
  task automatic t_reset();
    repeat (5) @(negedge clk);
    check(txd_out, 1'b1);
    check({req_oe, frm_oe, irdy_oe, ad_oe, tgt_oe, perr_oe, serr_oe, inta_oe}, 8'h00);
    check({req_n, frm_n, irdy_n, dev_n, trdy_n, stop_n, perr_n, done, abrt, cfg}, 10'h3f8);
    repeat (7) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check(txd_out, 1'b0);
    txd = 1'b1;
    $display("test reset done");
  endtask
  task automatic t_master();
    m_xfer(1'b0, 1'b1, 3'h0, t1);
    check({done_f, abrt_f, req_f}, 3'h5);
    check(adr_seen, {PBC_CMD_IO_WRITE, 32'h0000_1230});
    check(perr_f, 1'b0);
    m_xfer(1'b1, 1'b1, 3'h3, t2);
    check({done_f, abrt_f}, 2'h2);
    check(t2 > t1, 1'b1);
    $display("test master done");
  endtask
  task automatic t_abort();
    mask = 5'h10;
    m_xfer(1'b0, 1'b0, 3'h0, t1);
    check({abrt_f, done_f}, 2'h2);
    check(t1 >= 7 && t1 <= 16, 1'b1);
    check(inta_oe, 1'b0);
    mask = 5'h00;
    repeat (4) @(negedge clk);
    check(inta_oe, 1'b1);
    src = 4'h1;
    @(negedge clk);
    {src, ack} = {4'h0, 5'h10};
    @(negedge clk);
    ack = 5'h00;
    repeat (4) @(negedge clk);
    check(inta_oe, 1'b1);
    ack = 5'h01;
    @(negedge clk);
    ack = 5'h00;
    repeat (4) @(negedge clk);
    check(inta_oe, 1'b0);
    $display("test abort done");
  endtask
  task automatic t_busy();
    div2 = 1'b0;
    claim = 1'b1;
    clear_flags();
    ext.frame_n = 1'b0;
    need = 1'b1;
    repeat (20) @(negedge clk);
    check(frm_oe, 1'b0);
    ext.frame_n = 1'b1;
    wait_on(end_f, 60);
    need = 1'b0;
    check(done_f, 1'b1);
    repeat (6) @(negedge clk);
    $display("test busy done");
  endtask
  task automatic t_cfg(input logic [3:0] cmd, input logic stp, input logic hit);
    @(negedge clk);
    clear_flags();
    stop_c = stp;
    ext = '{frame_n: 1'b0, irdy_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1, devsel_n: 1'b1,
            idsel: 1'b1, gnt_n: 1'b1, par: 1'b0, cbe_n: cmd, ad: 32'h0000_0040};
    @(negedge clk);
    {ext.frame_n, ext.irdy_n, ext.cbe_n, ext.idsel} = {~stp, 1'b0, 4'h0, 1'b0};
    if (stp)
      wait_on(stop_f, 30);
    else
      wait_on(dev_f, 30);
    check(cfg_f, hit);
    check({dev_f, wr_f}, hit ? {1'b1, cmd == PBC_CMD_IO_WRITE} : 2'h0);
    if (stp)
    begin
      repeat (10) @(negedge clk);
      check(stop_n, 1'b0);
      check(stop_f, 1'b1);
      ext.frame_n = 1'b1;
    end
    repeat (8) @(negedge clk);
    ext.irdy_n = 1'b1;
    repeat (8) @(negedge clk);
    check(tgt_oe, 1'b0);
    check(tr_f, hit && !stp);
    stop_c = 1'b0;
    $display("test config done");
  endtask
  task automatic t_errors();
    clear_flags();
    {ext.frame_n, ext.ad} = {1'b0, 32'h0000_00a5};
    flip = 1'b1;
    repeat (3) @(negedge clk);
    flip = 1'b0;
    wait_on(perr_f, 20);
    ext.frame_n = 1'b1;
    check(perr_f, 1'b1);
    check(serr_oe, 1'b0);
    fatal = 1'b1;
    @(negedge clk);
    fatal = 1'b0;
    wait_on(serr_f, 10);
    check(serr_f, 1'b1);
    $display("test errors done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    bad_count++;
    final_report();
  end
  initial
  begin
    t_reset();
    t_master();
    t_abort();
    t_busy();
    t_cfg(PBC_CMD_IO_READ, 1'b0, 1'b1);
    t_cfg(PBC_CMD_IO_WRITE, 1'b1, 1'b1);
    t_cfg(4'h6, 1'b0, 1'b0);
    t_errors();
    final_report();
  end
endmodule // pci_bus_control_signalling_tb_top
